// *** src/csg_exec.v ***
// Decode and execution of the compare-and-skip-if-greater instruction
`include "csg_defines.vh"
module csg_exec (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Phase and fetch stream
  input wire [1:0] PHASE,
  input wire [15:0] INSTR,
  input wire INSTR_VALID,
  input wire NEXT_TWO_WORD,
  input wire EXT_SET_EN,
  // Operands
  input wire [7:0] MEM_BYTE,
  input wire [7:0] WORK_REG,
  // Decode outputs
  output reg HIT,
  output reg [7:0] ADDR,
  output reg ACCESS_BANK,
  output reg BANK_SELECT_USE,
  output reg INDEXED_MODE,
  output reg SKIP,
  output reg NOP_CYCLE,
  output reg FLAGS_WE,
  output reg MEM_WE,
  output reg WORK_WE
);

  // One-hot sequencer states
  localparam ST_RUN = 3'b001;
  localparam ST_NOP1 = 3'b010;
  localparam ST_NOP2 = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg hit_q;
  reg hit_d;
  reg [7:0] addr_q;
  reg [7:0] addr_d;
  reg acc_q;
  reg acc_d;
  reg bsel_q;
  reg bsel_d;
  reg ilo_q;
  reg ilo_d;
  reg skip_q;
  reg skip_d;
  reg nop_q;
  reg nop_d;
  reg flags_we_q;
  reg mem_we_q;
  reg work_we_q;
  wire is_cmp;
  wire greater;
  wire end_cycle;
  wire [`CSG_BYTE_W:0] borrow;
  wire [`CSG_BYTE_W-1:0] diff;

  // Opcode match on the top seven bits
  function match_op;
    input [15:0] w;
    begin
      match_op = (w[`CSG_OPC_MSB:`CSG_OPC_LSB] == `CSG_OPC_VAL);
    end
  endfunction

  // Access flag clear selects the access bank; shared by three decoders
  function access_clear;
    input [15:0] w;
    begin
      access_clear = !w[`CSG_ACC_BIT];
    end
  endfunction

  // Literal offset window covers only the low part of the access bank
  function in_ilo_window;
    input [7:0] f;
    begin
      in_ilo_window = (f <= `CSG_ILO_MAX);
    end
  endfunction

  assign end_cycle = (PHASE == `CSG_PH_Q4);
  assign is_cmp = INSTR_VALID && (state_q == ST_RUN) && match_op(INSTR);

  // Ripple-borrow subtractor; only borrow out and zero test are used
  assign borrow[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < `CSG_BYTE_W; gi = gi + 1) begin : g_sub
      assign diff[gi] = MEM_BYTE[gi] ^ WORK_REG[gi] ^ borrow[gi];
      assign borrow[gi + 1] = (!MEM_BYTE[gi] && WORK_REG[gi]) || (!(MEM_BYTE[gi] ^ WORK_REG[gi]) && borrow[gi]);
    end
  endgenerate

  // Strictly greater: no borrow out and a non-zero difference
  assign greater = !borrow[`CSG_BYTE_W] && (diff != `CSG_ZERO_BYTE);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (is_cmp && end_cycle && greater) begin
          state_d = ST_NOP1;
        end
      end
      ST_NOP1: begin
        if (end_cycle) begin
          state_d = NEXT_TWO_WORD ? ST_NOP2 : ST_RUN;
        end
      end
      ST_NOP2: begin
        if (end_cycle) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @* begin
    hit_d = is_cmp;
    addr_d = is_cmp ? INSTR[7:0] : `CSG_RST_BYTE;
    acc_d = is_cmp && access_clear(INSTR);
    bsel_d = is_cmp && !access_clear(INSTR);
    // Low addresses remap to indexed literal offset only in extended mode
    ilo_d = is_cmp && access_clear(INSTR) && EXT_SET_EN && in_ilo_window(INSTR[7:0]);
    skip_d = is_cmp && end_cycle && greater;
    // Follows state_d so flag and sequencer move on one edge
    nop_d = (state_d != ST_RUN);
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_q <= `CSG_RST_BYTE;
    end else begin
      addr_q <= addr_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bsel_q <= 1'b0;
    end else begin
      bsel_q <= bsel_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ilo_q <= 1'b0;
    end else begin
      ilo_q <= ilo_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= skip_d;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= nop_d;
    end
  end

  // Compare only: strobes are flopped for clean ports but never raised
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_we_q <= 1'b0;
      mem_we_q <= 1'b0;
      work_we_q <= 1'b0;
    end else begin
      flags_we_q <= 1'b0;
      mem_we_q <= 1'b0;
      work_we_q <= 1'b0;
    end
  end

  // Ports mirror the flops with no logic between
  always @* begin
    HIT = hit_q;
    ADDR = addr_q;
    ACCESS_BANK = acc_q;
    BANK_SELECT_USE = bsel_q;
    INDEXED_MODE = ilo_q;
    SKIP = skip_q;
    NOP_CYCLE = nop_q;
    FLAGS_WE = flags_we_q;
    MEM_WE = mem_we_q;
    WORK_WE = work_we_q;
  end

endmodule // csg_exec

// *** src/csg_defines.vh ***
// Opcode fields, address limits and cycle codes for the compare-skip executor
`ifndef CSG_DEFINES_VH
`define CSG_DEFINES_VH
`define CSG_OPC_MSB 15
`define CSG_OPC_LSB 9
`define CSG_OPC_VAL 7'h32
`define CSG_ACC_BIT 8
`define CSG_ILO_MAX 8'h5F
`define CSG_PH_W 2
`define CSG_PH_Q4 2'h3
`define CSG_RST_BYTE 8'h00
`define CSG_ZERO_BYTE 8'h00
`define CSG_BYTE_W 8
`endif

// *** verification/csg_exec_asserts.sv ***
// Port checks for the compare-skip executor
module csg_exec_asserts(input wire CLK,RST_N,INSTR_VALID,NEXT_TWO_WORD,EXT_SET_EN,HIT,ACCESS_BANK,
  BANK_SELECT_USE,INDEXED_MODE,SKIP,NOP_CYCLE,FLAGS_WE,MEM_WE,WORK_WE,
  input wire [1:0] PHASE,input wire [15:0] INSTR,input wire [7:0] MEM_BYTE,WORK_REG,ADDR);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire m = INSTR_VALID && INSTR[15:9] == 7'h32 && !NOP_CYCLE;
  hit_match_a: assert property(m |=> HIT) else $error("hit");
  addr_field_a: assert property(m |=> ADDR == $past(INSTR[7:0])) else $error("addr");
  access_bank_a: assert property(m && !INSTR[8] |=> ACCESS_BANK) else $error("access");
  bank_select_a: assert property(m && INSTR[8] |=> BANK_SELECT_USE && !INDEXED_MODE) else $error("bank");
  indexed_mode_a: assert property(m && !INSTR[8] && EXT_SET_EN && INSTR[7:0] <= 8'h5F |=> INDEXED_MODE)
    else $error("indexed");
  indexed_off_a: assert property(m && (INSTR[8] || !EXT_SET_EN || INSTR[7:0] > 8'h5F) |=> !INDEXED_MODE)
    else $error("not indexed");
  skip_greater_a: assert property(m && PHASE == 2'h3 |=> SKIP == ($past(MEM_BYTE) > $past(WORK_REG)))
    else $error("skip");
  nop_length_a: assert property(SKIP |-> NOP_CYCLE[*4] ##1 NOP_CYCLE == $past(NEXT_TWO_WORD))
    else $error("nop");
  nop_second_a: assert property(SKIP ##4 NOP_CYCLE |-> NOP_CYCLE[*4] ##1 !NOP_CYCLE)
    else $error("nop two");
  no_write_a: assert property(!(FLAGS_WE || MEM_WE || WORK_WE)) else $error("write");
  nop_refuse_a: assert property(NOP_CYCLE |=> !HIT) else $error("refuse");
  cover property(SKIP);
  cover property(SKIP && NEXT_TWO_WORD);
  cover property(INDEXED_MODE);
  cover property(NOP_CYCLE && INSTR_VALID && INSTR[15:9] == 7'h32);
endmodule // csg_exec_asserts

// *** verification/csg_core_model.sv ***
// Phase sequencer and data memory at the far side
module csg_core_model(input wire CLK,RST_N,input wire [7:0] FA,output reg [1:0] PHASE,output wire [7:0] MEM_BYTE);
  timeunit 1ns;
  timeprecision 1ns;
  // Each byte holds its own address, keeping expectations trivial
  assign MEM_BYTE = FA;
  always @(negedge CLK or negedge RST_N) PHASE <= RST_N ? PHASE + 2'h1 : 2'h0;
endmodule // csg_core_model

// *** verification/testbench.sv ***
// Self-checking bench for the compare-skip executor
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  reg CLK=0,RST_N=0,v=0,t=0,e=0,s;
  reg [15:0] i=0;
  reg [7:0] w=0;
  wire [1:0] PHASE;
  wire [7:0] mb;
  wire SKIP,nop,hit;
  integer bad_count=0,samples_checked=0,n,x;
  always #5 CLK = ~CLK;
  csg_core_model pm(.CLK,.RST_N,.FA(i[7:0]),.PHASE,.MEM_BYTE(mb));
  csg_exec dut(.CLK,.RST_N,.PHASE,.INSTR(i),.INSTR_VALID(v),.NEXT_TWO_WORD(t),.EXT_SET_EN(e),.MEM_BYTE(mb),
    .WORK_REG(w),.HIT(hit),.ADDR(),.ACCESS_BANK(),.BANK_SELECT_USE(),.INDEXED_MODE(),.SKIP,.NOP_CYCLE(nop),
    .FLAGS_WE(),.MEM_WE(),.WORK_WE());
  task ex(input [15:0] xi,input [7:0] xw,input xt,xe,sk);
    @(posedge CLK iff PHASE == 2'h3) @(negedge CLK) {i,w,t,e,v} = {xi,xw,xt,xe,1'b1};
    repeat (4) @(negedge CLK);
    v = 0;
    s = SKIP;
    n = 0;
    x = sk ? (xt ? 8 : 4) : 0;
    while (nop && n < 20) begin
      n++;
      @(negedge CLK);
    end
    samples_checked++;
    if (s !== sk || n != x) begin
      bad_count++;
      $display("Error skip_nop expected %b %0d seen %b %0d", sk, x, s, n);
    end
    $display("test %h done", xi);
  endtask
  task test_skip_one;
    ex(16'h6580,8'h7F,0,0,1);
  endtask
  task test_equal_no_skip;
    ex(16'h6540,8'h40,1,0,0);
  endtask
  task test_skip_two_word;
    ex(16'h65FF,8'h00,1,0,1);
  endtask
  task test_indexed_less;
    ex(16'h645F,8'h60,0,1,0);
  endtask
  task test_indexed_edge;
    ex(16'h6460,8'h00,0,1,1);
  endtask
  task test_other_opcode;
    ex(16'h67FF,8'h00,0,0,0);
  endtask
  task test_refuse;
    reg h;
    begin
      @(posedge CLK iff PHASE == 2'h3) @(negedge CLK) {i,w,t,e,v} = {16'h6580,8'h00,1'b0,1'b0,1'b1};
      repeat (5) @(negedge CLK);
      h = 0;
      repeat (3) begin
        h = h | hit;
        @(negedge CLK);
      end
      // Match held through the no-op cycle must not be taken
      h = h | hit | nop;
      v = 0;
      samples_checked++;
      if (h !== 1'b0) begin
        bad_count++;
        $display("Error refuse_hit expected 0 seen %b", h);
      end
      $display("test refuse done");
    end
  endtask
  task end_of_test;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge CLK);
    RST_N = 1;
    test_skip_one;
    test_equal_no_skip;
    test_skip_two_word;
    test_indexed_less;
    test_indexed_edge;
    test_other_opcode;
    test_refuse;
    end_of_test;
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test;
  end
endmodule // testbench
bind csg_exec csg_exec_asserts ca(.CLK,.RST_N,.INSTR_VALID,.NEXT_TWO_WORD,.EXT_SET_EN,.HIT,.ACCESS_BANK,
  .BANK_SELECT_USE,.INDEXED_MODE,.SKIP,.NOP_CYCLE,.FLAGS_WE,.MEM_WE,.WORK_WE,.PHASE,.INSTR,.MEM_BYTE,.WORK_REG,.ADDR);
